// ---- hdl/pmg_defines.svh ----
`ifndef PMG_DEFINES_SVH
`define PMG_DEFINES_SVH

// Operation
// R01 - Bit 1 of gate control 1 stops the CAN controller when set and lets it run when clear.
// R02 - Bit 0 of gate control 1 stops the ADC when set and lets it run when clear.
// R03 - Bits 11 to 8 of gate control 2 each stop one input capture unit when set.
// R04 - Bits 3 to 0 of gate control 2 each stop one output compare unit when set.
// R05 - Bit 10 of gate control 3 stops the comparator block when set.
// R06 - Bit 3 of gate control 4 stops the reference clock output module when set.
// R07 - Bit 2 of gate control 4 stops the charge-time measurement unit when set.
// R08 - Bits 10 to 8 of gate control 6 each stop one PWM generator when set.
// R09 - Bit 4 of gate control 7 stops all four DMA channels together when set.
// R10 - Bit 12 of gate control 8 stops SENT channel b and bit 11 stops SENT channel a.
// R11 - Bit 8 of gate control 8 stops the deadman timer when set.
// R12 - Every unassigned bit reads zero and ignores writes.
// R13 - All implemented bits clear at reset so every present module starts enabled, and stay read/write.
// R14 - The CAN bit exists only on variants with CAN and otherwise acts as unimplemented.
// R15 - A module is stopped or started one cycle after its bit is set or cleared.
// R16 - A stopped module has its clocks halted and its register writes ignored, its reads undefined.
// R17 - One registered active-high enable per gated module equals the inverse of its bit.

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PMG_ADDR_CTRL_1 12'h000
`define PMG_ADDR_CTRL_2 12'h004
`define PMG_ADDR_CTRL_3 12'h008
`define PMG_ADDR_CTRL_4 12'h00C
`define PMG_ADDR_CTRL_6 12'h014
`define PMG_ADDR_CTRL_7 12'h018
`define PMG_ADDR_CTRL_8 12'h01C

// ----------------------------------------------------------------
// Writable masks (implemented bits)
// ----------------------------------------------------------------
`define PMG_MASK_CTRL_1_NOCAN 16'h0001
`define PMG_MASK_CTRL_1_CAN   16'h0003
`define PMG_MASK_CTRL_2       16'h0F0F
`define PMG_MASK_CTRL_3       16'h0400
`define PMG_MASK_CTRL_4       16'h000C
`define PMG_MASK_CTRL_6       16'h0700
`define PMG_MASK_CTRL_7       16'h0010
`define PMG_MASK_CTRL_8       16'h1900

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMG_BIT_ADC        0
`define PMG_BIT_CAN        1
`define PMG_LSB_COMPARE    0
`define PMG_LSB_CAPTURE    8
`define PMG_BIT_COMPARATOR 10
`define PMG_BIT_CHARGE     2
`define PMG_BIT_REFCLK     3
`define PMG_LSB_PWM        8
`define PMG_BIT_DMA        4
`define PMG_BIT_DEADMAN    8
`define PMG_BIT_SENT_A     11
`define PMG_BIT_SENT_B     12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMG_RESET_VALUE 16'h0000

`endif

// ---- hdl/pmg_gate_reg.sv ----
`timescale 1ns/1ps
`include "pmg_defines.svh"

// One gating register: only masked bits are stored, the rest read zero
module pmg_gate_reg #(
    parameter logic [15:0] MASK = 16'h0000
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    input  wire logic [1:0]  wr_strb,
    // Stored value
    output pmg_pkg::pmg_reg_t value_q
);

    pmg_pkg::pmg_reg_t merged;

    always_comb
    begin
        merged = value_q;
        if (wr_strb[0])
        begin
            merged[7:0] = wr_data[7:0];
        end
        if (wr_strb[1])
        begin
            merged[15:8] = wr_data[15:8];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            value_q <= `PMG_RESET_VALUE; // see R13
        end
        else if (wr_en)
        begin
            value_q <= merged & MASK; // see R12
        end
    end

endmodule

// ---- hdl/pmg_pkg.sv ----
package pmg_pkg;

    typedef logic [15:0] pmg_reg_t;

    typedef enum logic [2:0]
    {
        PMG_SEL_NONE = 3'h0,
        PMG_SEL_1    = 3'h1,
        PMG_SEL_2    = 3'h2,
        PMG_SEL_3    = 3'h3,
        PMG_SEL_4    = 3'h4,
        PMG_SEL_6    = 3'h5,
        PMG_SEL_7    = 3'h6,
        PMG_SEL_8    = 3'h7
    } pmg_sel_t;

endpackage

// ---- hdl/pmg_top.sv ----
`timescale 1ns/1ps
`include "pmg_defines.svh"

module pmg_top #(
    parameter bit HAS_CAN = 1'b1
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output wire logic        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output wire logic        s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output wire logic        s_axi_arready,
    // AXI4-Lite read data
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Module clock gate enables, high = module clocked
    output logic             adc_en_q,
    output logic             can_en_q,
    output logic      [3:0]  capture_unit_en_q,
    output logic      [3:0]  compare_unit_en_q,
    output logic             comparator_en_q,
    output logic             refclk_out_en_q,
    output logic             charge_time_unit_en_q,
    output logic      [2:0]  pwm_generator_en_q,
    output logic             dma_group_en_q,
    output logic             sent_channel_a_en_q,
    output logic             sent_channel_b_en_q,
    output logic             deadman_timer_en_q
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic pmg_pkg::pmg_sel_t decode(input logic [11:0] addr);
        logic [11:0] a;
        a = {addr[11:2], 2'b00};
        unique case (a)
            `PMG_ADDR_CTRL_1: decode = pmg_pkg::PMG_SEL_1;
            `PMG_ADDR_CTRL_2: decode = pmg_pkg::PMG_SEL_2;
            `PMG_ADDR_CTRL_3: decode = pmg_pkg::PMG_SEL_3;
            `PMG_ADDR_CTRL_4: decode = pmg_pkg::PMG_SEL_4;
            `PMG_ADDR_CTRL_6: decode = pmg_pkg::PMG_SEL_6;
            `PMG_ADDR_CTRL_7: decode = pmg_pkg::PMG_SEL_7;
            `PMG_ADDR_CTRL_8: decode = pmg_pkg::PMG_SEL_8;
            default:          decode = pmg_pkg::PMG_SEL_NONE;
        endcase
    endfunction

    // CAN bit only exists when the variant has the controller
    localparam logic [15:0] MASK_1 = HAS_CAN ? `PMG_MASK_CTRL_1_CAN : `PMG_MASK_CTRL_1_NOCAN; // see R14

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    logic              aw_held_q;
    logic [11:0]       aw_addr_q;
    logic              w_held_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              wr_fire;
    pmg_pkg::pmg_sel_t wr_sel;

    // Address and data are latched independently, then retired together
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_sel        = decode(aw_addr_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            // Unmapped addresses are answered with DECERR
            s_axi_bresp  <= (wr_sel == pmg_pkg::PMG_SEL_NONE) ? 2'h3 : 2'h0;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Gating registers
    // ----------------------------------------------------------------
    pmg_pkg::pmg_reg_t ctrl_1;
    pmg_pkg::pmg_reg_t ctrl_2;
    pmg_pkg::pmg_reg_t ctrl_3;
    pmg_pkg::pmg_reg_t ctrl_4;
    pmg_pkg::pmg_reg_t ctrl_6;
    pmg_pkg::pmg_reg_t ctrl_7;
    pmg_pkg::pmg_reg_t ctrl_8;

    pmg_gate_reg #(.MASK(MASK_1)) u_ctrl_1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_sel == pmg_pkg::PMG_SEL_1),
        .wr_data (w_data_q[15:0]),
        .wr_strb (w_strb_q[1:0]),
        .value_q (ctrl_1)
    );

    pmg_gate_reg #(.MASK(`PMG_MASK_CTRL_2)) u_ctrl_2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_sel == pmg_pkg::PMG_SEL_2),
        .wr_data (w_data_q[15:0]),
        .wr_strb (w_strb_q[1:0]),
        .value_q (ctrl_2)
    );

    pmg_gate_reg #(.MASK(`PMG_MASK_CTRL_3)) u_ctrl_3 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_sel == pmg_pkg::PMG_SEL_3),
        .wr_data (w_data_q[15:0]),
        .wr_strb (w_strb_q[1:0]),
        .value_q (ctrl_3)
    );

    pmg_gate_reg #(.MASK(`PMG_MASK_CTRL_4)) u_ctrl_4 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_sel == pmg_pkg::PMG_SEL_4),
        .wr_data (w_data_q[15:0]),
        .wr_strb (w_strb_q[1:0]),
        .value_q (ctrl_4)
    );

    pmg_gate_reg #(.MASK(`PMG_MASK_CTRL_6)) u_ctrl_6 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_sel == pmg_pkg::PMG_SEL_6),
        .wr_data (w_data_q[15:0]),
        .wr_strb (w_strb_q[1:0]),
        .value_q (ctrl_6)
    );

    pmg_gate_reg #(.MASK(`PMG_MASK_CTRL_7)) u_ctrl_7 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_sel == pmg_pkg::PMG_SEL_7),
        .wr_data (w_data_q[15:0]),
        .wr_strb (w_strb_q[1:0]),
        .value_q (ctrl_7)
    );

    pmg_gate_reg #(.MASK(`PMG_MASK_CTRL_8)) u_ctrl_8 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_fire && wr_sel == pmg_pkg::PMG_SEL_8),
        .wr_data (w_data_q[15:0]),
        .wr_strb (w_strb_q[1:0]),
        .value_q (ctrl_8)
    );

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    pmg_pkg::pmg_sel_t rd_sel;
    pmg_pkg::pmg_reg_t rd_value;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_sel        = decode(s_axi_araddr);

    always_comb
    begin
        unique case (rd_sel)
            pmg_pkg::PMG_SEL_1: rd_value = ctrl_1;
            pmg_pkg::PMG_SEL_2: rd_value = ctrl_2;
            pmg_pkg::PMG_SEL_3: rd_value = ctrl_3;
            pmg_pkg::PMG_SEL_4: rd_value = ctrl_4;
            pmg_pkg::PMG_SEL_6: rd_value = ctrl_6;
            pmg_pkg::PMG_SEL_7: rd_value = ctrl_7;
            pmg_pkg::PMG_SEL_8: rd_value = ctrl_8;
            pmg_pkg::PMG_SEL_NONE: rd_value = 16'h0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            // Upper half and unassigned bits always read zero
            s_axi_rdata  <= {16'h0000, rd_value}; // see R12
            s_axi_rresp  <= (rd_sel == pmg_pkg::PMG_SEL_NONE) ? 2'h3 : 2'h0;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Module enables
    // ----------------------------------------------------------------
    // Registered one cycle after the bit changes; the peripheral side
    // gates its clock and bus strobes from these, so a disabled module
    // ignores register writes and returns undefined reads.
    // One process per gating register keeps each enable group apart.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            adc_en_q              <= 1'b1;
            can_en_q              <= HAS_CAN;
        end
        else
        begin
            adc_en_q              <= !ctrl_1[`PMG_BIT_ADC];                       // see R02, R15, R17
            can_en_q              <= HAS_CAN && !ctrl_1[`PMG_BIT_CAN];            // see R01, R14
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            capture_unit_en_q     <= 4'hF;
            compare_unit_en_q     <= 4'hF;
        end
        else
        begin
            capture_unit_en_q     <= ~ctrl_2[`PMG_LSB_CAPTURE +: 4];              // see R03, R16
            compare_unit_en_q     <= ~ctrl_2[`PMG_LSB_COMPARE +: 4];              // see R04
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            comparator_en_q       <= 1'b1;
        end
        else
        begin
            comparator_en_q       <= !ctrl_3[`PMG_BIT_COMPARATOR];                // see R05
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            refclk_out_en_q       <= 1'b1;
            charge_time_unit_en_q <= 1'b1;
        end
        else
        begin
            refclk_out_en_q       <= !ctrl_4[`PMG_BIT_REFCLK];                    // see R06
            charge_time_unit_en_q <= !ctrl_4[`PMG_BIT_CHARGE];                    // see R07
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_generator_en_q    <= 3'h7;
        end
        else
        begin
            pwm_generator_en_q    <= ~ctrl_6[`PMG_LSB_PWM +: 3];                  // see R08
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_group_en_q        <= 1'b1;
        end
        else
        begin
            dma_group_en_q        <= !ctrl_7[`PMG_BIT_DMA];                       // see R09
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sent_channel_a_en_q   <= 1'b1;
            sent_channel_b_en_q   <= 1'b1;
            deadman_timer_en_q    <= 1'b1;
        end
        else
        begin
            sent_channel_a_en_q   <= !ctrl_8[`PMG_BIT_SENT_A];                    // see R10
            sent_channel_b_en_q   <= !ctrl_8[`PMG_BIT_SENT_B];                    // see R10
            deadman_timer_en_q    <= !ctrl_8[`PMG_BIT_DEADMAN];                   // see R11
        end
    end

endmodule

// ---- testbench/pmg_monitor.sv ----
`timescale 1ns/1ps
module pmg_monitor (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // Gate enables
    input wire logic        adc_en_q,
    input wire logic        comparator_en_q,
    input wire logic        dma_group_en_q,
    input wire logic        deadman_timer_en_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Only writes whose halves land on one edge are judged
    sequence s_take(logic [9:0] idx, logic lane);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[11:2] == idx && lane;
    endsequence

    property p_wr_answer;
        s_take(s_axi_awaddr[11:2], 1'b1) |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response missing");

    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data missing");

    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

    property p_adc;
        s_take(10'h000, s_axi_wstrb[0]) |-> ##3 adc_en_q == !$past(s_axi_wdata[0], 3);
    endproperty
    a_adc: assert property (p_adc) else $error("converter enable wrong");

    property p_cmp;
        s_take(10'h002, s_axi_wstrb[1]) |-> ##3 comparator_en_q == !$past(s_axi_wdata[10], 3);
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator enable wrong");

    property p_dma;
        s_take(10'h006, s_axi_wstrb[0]) |-> ##3 dma_group_en_q == !$past(s_axi_wdata[4], 3);
    endproperty
    a_dma: assert property (p_dma) else $error("dma enable wrong");

    property p_dmt;
        s_take(10'h007, s_axi_wstrb[1]) |-> ##3 deadman_timer_en_q == !$past(s_axi_wdata[8], 3);
    endproperty
    a_dmt: assert property (p_dmt) else $error("deadman enable wrong");

    property p_reset_en;
        $rose(aresetn) |-> adc_en_q && comparator_en_q && dma_group_en_q && deadman_timer_en_q;
    endproperty
    a_reset_en: assert property (p_reset_en) else $error("enables not set after reset");
endmodule

bind pmg_top pmg_monitor mon_u (.*);

// ---- testbench/pmg_periph_model.sv ----
`timescale 1ns/1ps
// Stand-in for the gated peripherals: each flips its activity bit on every clock it receives
module pmg_periph_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Gate enables, one per peripheral
    input  wire logic [19:0] en,
    // Activity bits
    output logic      [19:0] ran_q
);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ran_q <= 20'h00000;
        else
            ran_q <= ran_q ^ en;
    end
endmodule

// ---- testbench/tb_peripheral_module_gating.sv ----
`timescale 1ns/1ps
`include "pmg_defines.svh"
module tb_peripheral_module_gating;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, capture_unit_en_q, compare_unit_en_q;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        adc_en_q, can_en_q, comparator_en_q, refclk_out_en_q, charge_time_unit_en_q, dma_group_en_q;
    logic        sent_channel_a_en_q, sent_channel_b_en_q, deadman_timer_en_q;
    logic [2:0]  pwm_generator_en_q;
    logic [19:0] ran_q;
    int          errors = 0;
    int          n_compared = 0;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [15:0] sh[7];
    logic [31:0] seed = 32'hCF7CC04B;
    localparam logic [11:0] ADR[7] = '{`PMG_ADDR_CTRL_1, `PMG_ADDR_CTRL_2, `PMG_ADDR_CTRL_3, `PMG_ADDR_CTRL_4,
                                       `PMG_ADDR_CTRL_6, `PMG_ADDR_CTRL_7, `PMG_ADDR_CTRL_8};
    localparam logic [15:0] MSK[7] = '{16'h0003, 16'h0F0F, 16'h0400, 16'h000C, 16'h0700, 16'h0010, 16'h1900};
    wire logic [19:0] en_w = {can_en_q, adc_en_q, capture_unit_en_q, compare_unit_en_q, comparator_en_q,
                              refclk_out_en_q, charge_time_unit_en_q, pwm_generator_en_q, dma_group_en_q,
                              sent_channel_a_en_q, sent_channel_b_en_q, deadman_timer_en_q};

    pmg_top dut_u (.*);
    pmg_periph_model per_u (.aclk(aclk), .aresetn(aresetn), .en(en_w), .ran_q(ran_q));

    initial forever #12.5 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [19:0] en_exp();
        return ~{sh[0][1], sh[0][0], sh[1][11:8], sh[1][3:0], sh[2][10], sh[3][3], sh[3][2], sh[4][10:8],
                 sh[5][4], sh[6][11], sh[6][12], sh[6][8]};
    endfunction

    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Response watcher: every answer is matched against the oldest expectation
    always @(posedge aclk)
    begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready && rq.size() > 0)
            check("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid === 1'b1 && s_axi_bready && bq.size() > 0)
            check("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bq.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Waits for the answer however long it takes; the watchdog ends a hang
        while (!(s_axi_bvalid === 1'b1 && s_axi_bready))
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!(s_axi_rvalid === 1'b1 && s_axi_rready))
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Write, read back, then see that enables and peripheral clocks follow
    task automatic wc(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] bm;
        logic [19:0] r0;
        bm = {{8{s[1]}}, {8{s[0]}}};
        sh[i] = (sh[i] & ~bm) | (d[15:0] & MSK[i] & bm);
        wr(ADR[i], d, s, 2'h0);
        rd(ADR[i], {18'h0, sh[i]});
        check("enables", 34'(en_exp()), 34'(en_w));
        r0 = ran_q;
        @(posedge aclk);
        check("clocking", 34'(r0 ^ en_exp()), 34'(ran_q));
    endtask

    task automatic rd_all();
        for (int i = 0; i < 7; i++)
            rd(ADR[i], {18'h0, sh[i]});
        check("enables", 34'(en_exp()), 34'(en_w));
    endtask

    initial
    begin
        foreach (sh[i]) sh[i] = 16'h0000;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_all();
        for (int i = 0; i < 7; i++) wc(i, 32'hFFFFFFFF, 4'hF);
        wr(12'h010, 32'hFFFFFFFF, 4'hF, 2'h3);
        rd(12'h010, {2'h3, 32'h0});
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (sh[i]) sh[i] = 16'h0000;
        @(posedge aclk);
        rd_all();
        for (int i = 0; i < 21; i++) wc(i % 7, rnd(), 4'(rnd()));
        for (int i = 0; i < 7; i++) wc(i, 32'h0, 4'hF);
        conclude();
    end

    // About 340 cycles are needed; this leaves a wide margin
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        conclude();
    end
endmodule
